// *** core/dacc_ctrl.sv ***
// Converter data and mode control: APB registers and analog control outputs
//
// What this block does
// - Main 12-bit code sits at bits 27:16
// - Interpolation adds four low bits 15:12
// - Software selects reference source and span
// - Three modes: normal, interpolated, op-amp
// - Normal mode converts a 12-bit code
// - Buffer used unless bypass bit set
// - Interpolation gives 16 bits, slower updates
// - Interpolation update rate from rate field
// - Op-amp mode disables core, frees buffer
// - Mode bit one selects interpolation, zero normal, while the op-amp bit is clear
// - Rate bit: divide by 16 or 32
// - Edge bit: clock or timer falling edge
// - Clear zero forces output and code to zero
`timescale 1ns/1ps
`include "dacc_regs.svh"
module dacc_ctrl (
    input  wire logic                 ref_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 uart_domain_clock_i,
    input  wire logic                 timer_channel_zero_event_i,
    output logic [15:0]               conv_code_o,
    output logic                      conv_update_o,
    output dacc_pkg::dacc_range_t     conv_range_o,
    output dacc_pkg::dacc_mode_t      conv_mode_o,
    output logic                      conv_enable_o,
    output logic                      buffer_bypass_o,
    output logic                      buffer_low_power_o,
    output logic                      opamp_pins_en_o,
    output logic                      conv_power_down_o
);
    import dacc_pkg::*;

    logic [15:0] converter_control_reg;
    logic [31:0] converter_output_code;
    logic [15:0] ctrl_next;
    logic [31:0] code_next;
    logic        wr_stb;
    logic        sel_ctrl;
    logic        sel_code;
    logic        sel_stat;
    logic        hit;
    logic        clear_req;
    logic [31:0] rd_mux;
    dacc_mode_t  mode_next;

    dacc_upd_if upd ();

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    assign sel_ctrl = (paddr == `DACC_CTRL_OFFS);
    assign sel_code = (paddr == `DACC_CODE_OFFS);
    assign sel_stat = (paddr == `DACC_STAT_OFFS);
    assign hit      = sel_ctrl | sel_code | sel_stat;
    // Zero-wait slave: the access phase always completes
    assign wr_stb   = psel & penable & pwrite;
    assign rd_mux   = sel_ctrl ? {16'h0000, converter_control_reg}
                    : sel_code ? converter_output_code
                    : sel_stat ? {16'h0000, upd.out_code} : 32'h0000_0000;

    // ------------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------------
    assign ctrl_next = (wr_stb && sel_ctrl)
                     ? (pwdata[15:0] & `DACC_CTRL_MASK)
                     : converter_control_reg;
    // Clear held low keeps the code register at zero as well
    assign clear_req = ~ctrl_next[`DACC_CLEAR_BIT];
    assign code_next = clear_req ? `DACC_CODE_RST
                     : (wr_stb && sel_code)
                       ? (pwdata & `DACC_CODE_MASK)
                       : converter_output_code;

    // Op-amp bit overrides the interpolation selection
    assign mode_next = ctrl_next[`DACC_OPAMP_BIT] ? DACC_MODE_OPAMP
                     : ctrl_next[`DACC_INTERP_BIT] ? DACC_MODE_INTERP
                     : DACC_MODE_NORMAL;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            converter_control_reg <= `DACC_CTRL_RST;
            converter_output_code <= `DACC_CODE_RST;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            prdata                <= 32'h0000_0000;
        end else begin
            converter_control_reg <= ctrl_next;
            converter_output_code <= code_next;
            pready                <= psel & ~penable;
            pslverr               <= psel & ~penable & ~hit;
            prdata                <= (psel & ~penable & ~pwrite) ? rd_mux
                                   : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Analog control outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            conv_range_o       <= DACC_RANGE_INTREF;
            conv_mode_o        <= DACC_MODE_NORMAL;
            conv_enable_o      <= 1'b0;
            buffer_bypass_o    <= 1'b0;
            buffer_low_power_o <= 1'b0;
            opamp_pins_en_o    <= 1'b0;
            conv_power_down_o  <= 1'b1;
            conv_code_o        <= 16'h0000;
            conv_update_o      <= 1'b0;
        end else begin
            conv_range_o       <= dacc_range_t'(ctrl_next[1:0]);
            conv_mode_o        <= mode_next;
            // Power-down in op-amp mode is left to software
            conv_enable_o      <= ~ctrl_next[`DACC_OPAMP_BIT]
                                & ~ctrl_next[`DACC_PDOWN_BIT];
            buffer_bypass_o    <= ctrl_next[`DACC_BYPASS_BIT];
            buffer_low_power_o <= ctrl_next[`DACC_BUFLP_BIT];
            opamp_pins_en_o    <= ctrl_next[`DACC_OPAMP_BIT];
            conv_power_down_o  <= ctrl_next[`DACC_PDOWN_BIT];
            conv_code_o        <= clear_req ? 16'h0000 : upd.out_code;
            conv_update_o      <= upd.upd_pulse;
        end
    end

    // ------------------------------------------------------------------------
    // Update engine
    // ------------------------------------------------------------------------
    assign upd.interp     = converter_control_reg[`DACC_INTERP_BIT];
    assign upd.rate_fast  = converter_control_reg[`DACC_RATE_BIT];
    assign upd.edge_timer = converter_control_reg[`DACC_EDGE_BIT];
    assign upd.clear      = ~converter_control_reg[`DACC_CLEAR_BIT];
    assign upd.timer_evt  = timer_channel_zero_event_i;
    assign upd.uart_clk   = uart_domain_clock_i;
    assign upd.code       = {converter_output_code[`DACC_MAIN_HI:
                                                   `DACC_MAIN_LO],
                             converter_output_code[`DACC_EXTRA_HI:
                                                   `DACC_EXTRA_LO]};

    dacc_update u_update (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .upd       (upd)
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence clr_write_s;
        wr_stb && sel_ctrl && !pwdata[`DACC_CLEAR_BIT];
    endsequence

    clear_code_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        clr_write_s |=> converter_output_code == 32'h0 ##1 conv_code_o == 16'h0)
        else $error("clear did not zero code and output");
    reserved_zero_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        (converter_output_code & ~`DACC_CODE_MASK) == 32'h0)
        else $error("reserved code bits not zero");
    code_write_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        wr_stb && sel_code && converter_control_reg[`DACC_CLEAR_BIT]
        && ctrl_next[`DACC_CLEAR_BIT]
        |=> converter_output_code[27:16] == $past(pwdata[27:16]))
        else $error("main code field not stored");
    normal_low_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !upd.interp |=> upd.out_code[3:0] == 4'h0 || $past(upd.interp))
        else $error("normal mode used extra bits");
    opamp_mode_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        converter_control_reg[`DACC_OPAMP_BIT]
        |=> opamp_pins_en_o && !conv_enable_o
            && conv_mode_o == DACC_MODE_OPAMP || $past(wr_stb))
        else $error("op-amp mode not applied");
    interp_mode_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !$past(wr_stb) && converter_control_reg[`DACC_INTERP_BIT]
        && !converter_control_reg[`DACC_OPAMP_BIT]
        |-> conv_mode_o == DACC_MODE_INTERP)
        else $error("interpolation mode not shown");
    bypass_out_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !$past(wr_stb) |-> buffer_bypass_o
            == converter_control_reg[`DACC_BYPASS_BIT])
        else $error("bypass output mismatch");
    range_out_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !$past(wr_stb) |-> conv_range_o == converter_control_reg[1:0])
        else $error("range output mismatch");
    edge_timer_a: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        upd.edge_timer && !upd.clear && u_update.fire
        |-> $past(timer_channel_zero_event_i)
            && !timer_channel_zero_event_i)
        else $error("timer update off its falling edge");
endmodule

// *** common/dacc_regs.svh ***
// Register offsets, field positions and reset values of the converter control
`ifndef DACC_REGS_SVH
`define DACC_REGS_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define DACC_CTRL_OFFS      12'h600
`define DACC_CODE_OFFS      12'h604
`define DACC_STAT_OFFS      12'h608

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define DACC_CTRL_RST       16'h0200
`define DACC_CTRL_MASK      16'h03ff
`define DACC_RANGE_LO       0
`define DACC_RANGE_HI       1
`define DACC_RATE_BIT       2
`define DACC_INTERP_BIT     3
`define DACC_CLEAR_BIT      4
`define DACC_EDGE_BIT       5
`define DACC_BYPASS_BIT     6
`define DACC_OPAMP_BIT      7
`define DACC_BUFLP_BIT      8
`define DACC_PDOWN_BIT      9

// ----------------------------------------------------------------------------
// Output code fields
// ----------------------------------------------------------------------------
`define DACC_CODE_RST       32'h0000_0000
`define DACC_CODE_MASK      32'h0fff_f000
`define DACC_MAIN_HI        27
`define DACC_MAIN_LO        16
`define DACC_EXTRA_HI       15
`define DACC_EXTRA_LO       12

// ----------------------------------------------------------------------------
// Interpolation clock dividers
// ----------------------------------------------------------------------------
`define DACC_DIV_FAST       6'd16
`define DACC_DIV_SLOW       6'd32

`endif

// *** common/dacc_pkg.sv ***
// Types shared by the converter control block
package dacc_pkg;

    typedef enum logic [1:0] {
        DACC_RANGE_INTREF,
        DACC_RANGE_EXTREF,
        DACC_RANGE_ALTREF,
        DACC_RANGE_SUPPLY
    } dacc_range_t;

    typedef enum logic [1:0] {
        DACC_MODE_NORMAL,
        DACC_MODE_INTERP,
        DACC_MODE_OPAMP
    } dacc_mode_t;

endpackage

// *** common/dacc_upd_if.sv ***
// Carrier between the register block and the update engine
`timescale 1ns/1ps
interface dacc_upd_if;
    logic        interp;
    logic        rate_fast;
    logic        edge_timer;
    logic        clear;
    logic        timer_evt;
    logic        uart_clk;
    logic [15:0] code;
    logic [15:0] out_code;
    logic        upd_pulse;

    modport ctrl (
        output interp, rate_fast, edge_timer, clear, timer_evt, uart_clk, code,
        input  out_code, upd_pulse
    );
    modport eng (
        input  interp, rate_fast, edge_timer, clear, timer_evt, uart_clk, code,
        output out_code, upd_pulse
    );
endinterface

// *** core/dacc_update.sv ***
// Update engine: picks the update moment and the interpolation clock
`timescale 1ns/1ps
module dacc_update (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    dacc_upd_if.eng   upd
);
    import dacc_pkg::*;

    logic       uart_domain_clock_q1_reg;
    logic       uart_domain_clock_q2_reg;
    logic       uart_domain_clock_q3_reg;
    logic [5:0] div_cnt_reg;
    logic [5:0] div_cnt_next;
    logic       tmr_q_reg;
    logic       uart_domain_clock_rise;
    logic       interp_tick;
    logic       tmr_fall;
    logic       fire;
    logic [5:0] div_top;

    // ------------------------------------------------------------------------
    // Update timing
    // ------------------------------------------------------------------------
    // Edges of the uart domain clock sampled here; it is well below 200 MHz
    assign uart_domain_clock_rise    = uart_domain_clock_q2_reg & ~uart_domain_clock_q3_reg;
    assign div_top      = upd.rate_fast ? `DACC_DIV_FAST : `DACC_DIV_SLOW;
    // At-or-above compare: a switch from /32 to /16 must not run to wrap
    assign interp_tick  = uart_domain_clock_rise && (div_cnt_reg >= div_top - 6'd1);
    assign div_cnt_next = interp_tick ? 6'd0
                        : uart_domain_clock_rise ? div_cnt_reg + 6'd1 : div_cnt_reg;
    assign tmr_fall     = tmr_q_reg & ~upd.timer_evt;
    // Timer fall or every clock; interpolation waits for its slower tick
    assign fire = (upd.edge_timer ? tmr_fall : 1'b1)
                & (~upd.interp | interp_tick);

    always_ff @(posedge ref_clk_i) begin
        uart_domain_clock_q1_reg <= upd.uart_clk;
        uart_domain_clock_q2_reg <= uart_domain_clock_q1_reg;
        uart_domain_clock_q3_reg <= uart_domain_clock_q2_reg;
        tmr_q_reg   <= upd.timer_evt;
        if (sys_rst_i) begin
            div_cnt_reg <= 6'd0;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // Output code: clear acts at once, otherwise loads on the update moment
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || upd.clear) begin
            upd.out_code  <= 16'h0000;
            upd.upd_pulse <= 1'b0;
        end else begin
            upd.upd_pulse <= fire;
            if (fire) begin
                upd.out_code <= upd.interp ? upd.code
                              : {upd.code[15:4], 4'h0};
            end else if (!upd.interp) begin
                // Extra bits drop at once when interpolation is left
                upd.out_code[3:0] <= 4'h0;
            end
        end
    end

    interp_slow_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        upd.interp && !upd.clear && fire |-> interp_tick)
        else $error("interpolated update without interpolation tick");
    div_bound_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        div_cnt_reg < `DACC_DIV_SLOW)
        else $error("interpolation divider out of range");
endmodule

// *** verification/tb.sv ***
// Register-level bench for the converter data and mode control block
`timescale 1ns/1ps
`include "dacc_regs.svh"
module tb;
    import dacc_pkg::*;
    logic        ref_clk_i;
    logic        sys_rst_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        uart_clk = 1'b0;
    logic        timer_evt;
    logic [15:0] conv_code_o;
    logic        conv_update_o;
    dacc_range_t conv_range_o;
    dacc_mode_t  conv_mode_o;
    logic        conv_enable_o;
    logic        buffer_bypass_o;
    logic        buffer_low_power_o;
    logic        opamp_pins_en_o;
    logic        conv_power_down_o;
    logic [1:0]  uart_div = 2'd0;
    logic [31:0] rd;
    logic        er;
    int          err_count;
    int          compares;

    dacc_ctrl i_dut (
        .ref_clk_i                  (ref_clk_i),
        .sys_rst_i                  (sys_rst_i),
        .psel                       (psel),
        .penable                    (penable),
        .pwrite                     (pwrite),
        .paddr                      (paddr),
        .pwdata                     (pwdata),
        .pready                     (pready),
        .prdata                     (prdata),
        .pslverr                    (pslverr),
        .uart_domain_clock_i        (uart_clk),
        .timer_channel_zero_event_i (timer_evt),
        .conv_code_o                (conv_code_o),
        .conv_update_o              (conv_update_o),
        .conv_range_o               (conv_range_o),
        .conv_mode_o                (conv_mode_o),
        .conv_enable_o              (conv_enable_o),
        .buffer_bypass_o            (buffer_bypass_o),
        .buffer_low_power_o         (buffer_low_power_o),
        .opamp_pins_en_o            (opamp_pins_en_o),
        .conv_power_down_o          (conv_power_down_o)
    );

    // ------------------------------------------------------------------
    // Clocks
    // ------------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // Slow clock: one rising edge every 8 system cycles
    always @(posedge ref_clk_i) begin
        uart_div <= uart_div + 2'd1;
        if (uart_div == 2'd3)
            uart_clk <= ~uart_clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_code(input logic [15:0] exp, input int lim);
        int n;
        n = 0;
        while (conv_code_o !== exp && n < lim) begin
            @(posedge ref_clk_i);
            n++;
        end
        check({16'h0000, conv_code_o}, {16'h0000, exp}, "output code");
        if (conv_code_o !== exp)
            tally_and_finish();
    endtask

    task automatic count_upd(input int cyc, input int lo, input int hi);
        int n;
        n = 0;
        repeat (cyc) begin
            @(posedge ref_clk_i);
            if (conv_update_o === 1'b1)
                n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1, "update count");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {err_count, compares} = '0;
        timer_evt = 1'b1;
        sys_rst_i = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;

        apb(0, `DACC_CTRL_OFFS, 0);
        check(rd, 32'h0000_0200, "control reset");
        apb(0, `DACC_CODE_OFFS, 0);
        check(rd, `DACC_CODE_RST, "code reset");
        check(conv_power_down_o, 1'b1, "power down at reset");
        $display("test reset done");

        apb(1, `DACC_CTRL_OFFS, 32'hffff_fc10);
        apb(0, `DACC_CTRL_OFFS, 0);
        check(rd, 32'h0000_0010, "control reserved");
        apb(1, `DACC_CODE_OFFS, 32'hffff_ffff);
        apb(0, `DACC_CODE_OFFS, 0);
        check(rd, 32'h0fff_f000, "code reserved");
        wait_code(16'hfff0, 10);
        check(conv_mode_o, DACC_MODE_NORMAL, "normal mode");
        count_upd(20, 18, 20);
        $display("test normal done");

        for (int r = 0; r < 4; r++) begin
            apb(1, `DACC_CTRL_OFFS, 32'h10 | r);
            repeat (2) @(posedge ref_clk_i);
            check(conv_range_o, r, "range");
        end
        $display("test ranges done");

        apb(1, `DACC_CTRL_OFFS, 32'h1c);
        apb(1, `DACC_CODE_OFFS, 32'h0abc_5000);
        wait_code(16'habc5, 400);
        check(conv_mode_o, DACC_MODE_INTERP, "interp mode");
        count_upd(768, 5, 7);
        apb(1, `DACC_CTRL_OFFS, 32'h18);
        count_upd(768, 2, 4);
        $display("test interpolation done");

        apb(1, `DACC_CTRL_OFFS, 32'h30);
        apb(1, `DACC_CODE_OFFS, 32'h0123_0000);
        count_upd(20, 0, 0);
        check(32'(conv_code_o == 16'h1230), 32'h0, "held code");
        timer_evt <= 1'b0;
        wait_code(16'h1230, 10);
        timer_evt <= 1'b1;
        apb(0, `DACC_STAT_OFFS, 0);
        check(rd, 32'h0000_1230, "status code");
        check({31'h0, er}, 32'h0, "status no error");
        $display("test timer edge done");

        apb(1, `DACC_CTRL_OFFS, 32'h3d8);
        repeat (2) @(posedge ref_clk_i);
        check(conv_mode_o, DACC_MODE_OPAMP, "opamp mode");
        check(conv_enable_o, 1'b0, "core off");
        check(opamp_pins_en_o, 1'b1, "opamp pins");
        check(conv_power_down_o, 1'b1, "power down");
        check(buffer_bypass_o, 1'b1, "bypass");
        check(buffer_low_power_o, 1'b1, "low power");
        apb(1, `DACC_CTRL_OFFS, 32'h10);
        repeat (2) @(posedge ref_clk_i);
        check(buffer_bypass_o, 1'b0, "buffer used");
        check(conv_enable_o, 1'b1, "core on");
        $display("test opamp done");

        apb(1, `DACC_CTRL_OFFS, 32'h00);
        apb(0, `DACC_CODE_OFFS, 0);
        check(rd, 32'h0, "code cleared");
        wait_code(16'h0000, 3);
        apb(0, 12'h70c, 0);
        check({31'h0, er}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        $display("test clear done");

        apb(1, `DACC_CTRL_OFFS, 32'h1d0);
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        apb(0, `DACC_CTRL_OFFS, 0);
        check(rd, 32'h0000_0200, "control after reset");
        check(buffer_low_power_o, 1'b0, "low power after reset");
        check(conv_power_down_o, 1'b1, "power down after reset");
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule
